// >>> verilog/tfp_timer16_pwm.sv
// 16-bit timer with fast and phase-correct pwm waveform generation, avalon-mm slave
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module tfp_timer16_pwm #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // waveform and pins
  output logic waveform_output_a,
  output logic waveform_output_b,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output logic timer_clock_enable
);

  generate
    if (ADDR_W < 5) begin : g_chk
      $error("ADDR_W must be at least 5");
    end
  endgenerate

  tfp_pkg::tfp_state_s s_reg;
  tfp_pkg::tfp_state_s s_next;

  tfp_pkg::tfp_family_e fam;
  logic [15:0] top;
  logic [15:0] wmask;
  logic top_is_cmpa;
  logic top_is_capt;
  logic at_top;
  logic match_a;
  logic match_b;
  logic slope_down;
  logic [3:0] set_f;
  logic [3:0] clr_f;
  logic [31:0] bemask;
  logic [31:0] ctrl_view;
  logic [31:0] pin_view;
  logic [31:0] merged;
  logic [4:0] ofs;
  logic hit_wr;

  // merge write data into a register view under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [31:0] m);
    be_merge = (old & ~m) | (wd & m);
  endfunction

  // decode mode into family, top source and write mask
  always_comb begin
    fam = tfp_pkg::FAM_OFF;
    top = tfp_pkg::TOP_MAX;
    wmask = tfp_pkg::TOP_MAX;
    top_is_cmpa = 1'b0;
    top_is_capt = 1'b0;
    // other codes hold the counter: only pwm families are served here
    unique case (s_reg.mode)
      tfp_pkg::MODE_FAST8, tfp_pkg::MODE_PC8: begin
        top = tfp_pkg::TOP_8BIT; // R2 R14
        wmask = tfp_pkg::TOP_8BIT; // R7
      end
      tfp_pkg::MODE_FAST9, tfp_pkg::MODE_PC9: begin
        top = tfp_pkg::TOP_9BIT; // R2 R14
        wmask = tfp_pkg::TOP_9BIT; // R7
      end
      tfp_pkg::MODE_FAST10, tfp_pkg::MODE_PC10: begin
        top = tfp_pkg::TOP_10BIT; // R2 R14
        wmask = tfp_pkg::TOP_10BIT; // R7
      end
      tfp_pkg::MODE_FAST_CAPT, tfp_pkg::MODE_PC_CAPT: begin
        top = s_reg.icr; // R8
        top_is_capt = 1'b1;
      end
      tfp_pkg::MODE_FAST_CMPA, tfp_pkg::MODE_PC_CMPA: begin
        top = s_reg.ocra;
        top_is_cmpa = 1'b1;
      end
      default: begin
        top = tfp_pkg::TOP_MAX;
      end
    endcase
    unique case (s_reg.mode)
      tfp_pkg::MODE_FAST8, tfp_pkg::MODE_FAST9, tfp_pkg::MODE_FAST10,
      tfp_pkg::MODE_FAST_CAPT, tfp_pkg::MODE_FAST_CMPA: begin
        fam = tfp_pkg::FAM_FAST; // R1
      end
      tfp_pkg::MODE_PC8, tfp_pkg::MODE_PC9, tfp_pkg::MODE_PC10,
      tfp_pkg::MODE_PC_CAPT, tfp_pkg::MODE_PC_CMPA: begin
        fam = tfp_pkg::FAM_PHASE; // R13
      end
      default: begin
        fam = tfp_pkg::FAM_OFF;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    set_f = 4'h0;
    clr_f = 4'h0;
    at_top = (s_reg.cnt == top);
    match_a = (s_reg.cnt == s_reg.ocra);
    match_b = (s_reg.cnt == s_reg.ocrb);
    // at TOP the slope is already falling, at BOTTOM already rising
    slope_down = at_top | (s_reg.down & (s_reg.cnt != 16'h0000));
    bemask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    ofs = address[4:0];
    ctrl_view = 32'h00000000;
    ctrl_view[tfp_pkg::CTRL_MODE_LSB +: 4] = s_reg.mode;
    ctrl_view[tfp_pkg::CTRL_COMA_LSB +: 2] = s_reg.com_a;
    ctrl_view[tfp_pkg::CTRL_COMB_LSB +: 2] = s_reg.com_b;
    ctrl_view[tfp_pkg::CTRL_CS_LSB +: 3] = s_reg.cs;
    pin_view = 32'h00000000;
    pin_view[tfp_pkg::PIN_DIR_LSB +: 2] = s_reg.dir;
    pin_view[tfp_pkg::PIN_ROUTE_LSB +: 2] = s_reg.route;
    merged = 32'h00000000;
    hit_wr = write & ~s_reg.wait_req;

    // prescaler, free running so a select change takes effect at the next tap
    s_next.presc = s_reg.presc + 10'h001;
    unique case (s_reg.cs)
      tfp_pkg::CS_DIV1: s_next.tick = 1'b1; // R21
      tfp_pkg::CS_DIV8: s_next.tick = ((s_reg.presc & tfp_pkg::TAP_DIV8) == tfp_pkg::TAP_DIV8); // R21
      tfp_pkg::CS_DIV64: s_next.tick = ((s_reg.presc & tfp_pkg::TAP_DIV64) == tfp_pkg::TAP_DIV64); // R21
      tfp_pkg::CS_DIV256: s_next.tick = ((s_reg.presc & tfp_pkg::TAP_DIV256) == tfp_pkg::TAP_DIV256); // R21
      tfp_pkg::CS_DIV1024: s_next.tick = (s_reg.presc == tfp_pkg::TAP_DIV1024); // R21
      default: s_next.tick = 1'b0;
    endcase

    // timer logic, only on the timer clock enable
    if (s_reg.tick && fam != tfp_pkg::FAM_OFF) begin // R24
      if (match_a) begin
        set_f[tfp_pkg::FLG_CMPA] = 1'b1; // R6
      end
      if (match_b) begin
        set_f[tfp_pkg::FLG_CMPB] = 1'b1; // R6
      end
      if (fam == tfp_pkg::FAM_FAST) begin
        if (at_top) begin
          s_next.cnt = 16'h0000; // R1 R2
          set_f[tfp_pkg::FLG_OVF] = 1'b1; // R5
          set_f[tfp_pkg::FLG_CMPA] = top_is_cmpa | match_a; // R5
          set_f[tfp_pkg::FLG_CAPT] = top_is_capt; // R5
          s_next.ocra = s_reg.bufa; // R9
          s_next.ocrb = s_reg.bufb; // R9
          // top action first so a match at TOP wins and gives a constant level
          if (s_reg.com_a == tfp_pkg::COM_NONINV) s_next.wf_a = 1'b0; // R3
          if (s_reg.com_a == tfp_pkg::COM_INV) s_next.wf_a = 1'b1; // R3
          if (s_reg.com_b == tfp_pkg::COM_NONINV) s_next.wf_b = 1'b0; // R3
          if (s_reg.com_b == tfp_pkg::COM_INV) s_next.wf_b = 1'b1; // R3
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001; // R1 R8
        end
        if (match_a) begin
          unique case (s_reg.com_a) // R4 R22
            tfp_pkg::COM_TOGGLE: s_next.wf_a = ~s_reg.wf_a; // R11
            tfp_pkg::COM_NONINV: s_next.wf_a = 1'b1; // R3 R10
            tfp_pkg::COM_INV: s_next.wf_a = 1'b0; // R3 R10
            tfp_pkg::COM_OFF: s_next.wf_a = s_reg.wf_a; // R22
          endcase
        end
        if (match_b) begin
          if (s_reg.com_b == tfp_pkg::COM_NONINV) s_next.wf_b = 1'b1; // R3 R4 R10
          if (s_reg.com_b == tfp_pkg::COM_INV) s_next.wf_b = 1'b0; // R3 R4 R10
        end
      end else begin
        if (!s_reg.down && at_top) begin
          s_next.down = 1'b1; // R13 R14
          s_next.cnt = s_reg.cnt - 16'h0001; // R14
          set_f[tfp_pkg::FLG_CMPA] = top_is_cmpa | match_a; // R16
          set_f[tfp_pkg::FLG_CAPT] = top_is_capt; // R16
          s_next.ocra = s_reg.bufa; // R16
          s_next.ocrb = s_reg.bufb; // R16
        end else if (s_reg.down && s_reg.cnt == 16'h0000) begin
          s_next.down = 1'b0; // R13
          s_next.cnt = 16'h0001;
          set_f[tfp_pkg::FLG_OVF] = 1'b1; // R16
        end else if (s_reg.down) begin
          s_next.cnt = s_reg.cnt - 16'h0001; // R13
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001; // R13 R8
        end
        if (match_a) begin
          if (s_reg.com_a == tfp_pkg::COM_NONINV) s_next.wf_a = slope_down; // R15 R17 R4
          if (s_reg.com_a == tfp_pkg::COM_INV) s_next.wf_a = ~slope_down; // R15 R17 R4
        end
        if (match_b) begin
          if (s_reg.com_b == tfp_pkg::COM_NONINV) s_next.wf_b = slope_down; // R15 R17 R4
          if (s_reg.com_b == tfp_pkg::COM_INV) s_next.wf_b = ~slope_down; // R15 R17 R4
        end
      end
    end

    // bus: waitrequest drops one cycle after a request; read data loads on that edge, a write lands on the next
    s_next.wait_req = 1'b1;
    if ((read || write) && s_reg.wait_req) begin
      s_next.wait_req = 1'b0;
    end
    if (read && s_reg.wait_req) begin
      unique case (ofs)
        tfp_pkg::OFS_CTRL: s_next.rdata = ctrl_view;
        tfp_pkg::OFS_COUNT: s_next.rdata = {16'h0000, s_reg.cnt};
        tfp_pkg::OFS_CMPA: s_next.rdata = {16'h0000, s_reg.bufa};
        tfp_pkg::OFS_CMPB: s_next.rdata = {16'h0000, s_reg.bufb};
        tfp_pkg::OFS_CAPT: s_next.rdata = {16'h0000, s_reg.icr};
        tfp_pkg::OFS_FLAGS: s_next.rdata = {28'h0000000, s_reg.flags};
        tfp_pkg::OFS_PINCFG: s_next.rdata = pin_view;
        default: s_next.rdata = tfp_pkg::RDATA_IDLE;
      endcase
    end
    if (hit_wr) begin
      unique case (ofs)
        tfp_pkg::OFS_CTRL: begin
          merged = be_merge(ctrl_view, writedata, bemask);
          s_next.mode = merged[tfp_pkg::CTRL_MODE_LSB +: 4];
          s_next.com_a = merged[tfp_pkg::CTRL_COMA_LSB +: 2];
          s_next.com_b = merged[tfp_pkg::CTRL_COMB_LSB +: 2];
          s_next.cs = merged[tfp_pkg::CTRL_CS_LSB +: 3];
        end
        tfp_pkg::OFS_COUNT: begin
          merged = be_merge({16'h0000, s_reg.cnt}, writedata, bemask);
          s_next.cnt = merged[15:0];
        end
        tfp_pkg::OFS_CMPA: begin
          merged = be_merge({16'h0000, s_reg.bufa}, writedata, bemask);
          s_next.bufa = merged[15:0] & wmask; // R7 R9
          if (fam == tfp_pkg::FAM_OFF) s_next.ocra = merged[15:0];
        end
        tfp_pkg::OFS_CMPB: begin
          merged = be_merge({16'h0000, s_reg.bufb}, writedata, bemask);
          s_next.bufb = merged[15:0] & wmask; // R7
          if (fam == tfp_pkg::FAM_OFF) s_next.ocrb = merged[15:0];
        end
        tfp_pkg::OFS_CAPT: begin
          merged = be_merge({16'h0000, s_reg.icr}, writedata, bemask);
          s_next.icr = merged[15:0]; // R8
        end
        tfp_pkg::OFS_FLAGS: begin
          merged = writedata & bemask;
          clr_f = merged[3:0];
        end
        tfp_pkg::OFS_PINCFG: begin
          merged = be_merge(pin_view, writedata, bemask);
          s_next.dir = merged[tfp_pkg::PIN_DIR_LSB +: 2];
          s_next.route = merged[tfp_pkg::PIN_ROUTE_LSB +: 2];
        end
        default: begin
          merged = 32'h00000000;
        end
      endcase
    end
    // a hardware set in the clearing cycle survives
    s_next.flags = (s_reg.flags & ~clr_f) | set_f;

    s_next.pin_a = s_next.wf_a;
    s_next.pin_b = s_next.wf_b;
    s_next.pin_a_oe = s_next.dir[0] & s_next.route[0] & (s_next.com_a != tfp_pkg::COM_OFF); // R12
    s_next.pin_b_oe = s_next.dir[1] & s_next.route[1] & (s_next.com_b != tfp_pkg::COM_OFF); // R12
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0; // R23
      s_reg.wait_req <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata = s_reg.rdata;
  assign waitrequest = s_reg.wait_req;
  assign waveform_output_a = s_reg.wf_a;
  assign waveform_output_b = s_reg.wf_b;
  assign pin_a_out = s_reg.pin_a;
  assign pin_a_oe = s_reg.pin_a_oe;
  assign pin_b_out = s_reg.pin_b;
  assign pin_b_oe = s_reg.pin_b_oe;
  assign timer_clock_enable = s_reg.tick;

endmodule

// >>> verilog/tfp_pkg.sv
// constants and types for the 16-bit timer pwm waveform block
// Function
// R1: fast pwm codes count up from BOTTOM to TOP, then restart at BOTTOM.
// R2: fast TOP is 0x00FF/0x01FF/0x03FF, capture or compare A; clear after TOP.
// R3: fast non-inverting sets on match, clears at TOP; inverting does opposite.
// R4: compare output mode 2 is non-inverted pwm, 3 is inverted pwm.
// R5: fast pwm sets overflow at TOP, plus compare A or capture flag.
// R6: a channel flag sets whenever the count equals its compare register.
// R7: fixed TOP modes mask compare bits above the resolution on write.
// R8: capture TOP is unbuffered; written below count, counter wraps through 0xFFFF.
// R9: fast pwm buffers compare A, loaded at TOP with counter clear.
// R10: compare zero gives a one-cycle spike; compare at TOP gives constant level.
// R11: channel A mode 1 in fast pwm toggles on match, buffering kept.
// R12: pin driven only with direction bit and pin route enable set.
// R13: phase-correct codes count up to TOP and back down to BOTTOM.
// R14: phase TOP is fixed, capture or compare A; held one timer cycle.
// R15: phase non-inverting clears on up-match, sets on down-match; inverting opposite.
// R16: phase pwm sets overflow at BOTTOM, loads buffers and TOP flag at TOP.
// R17: phase compare at BOTTOM stays low, at TOP stays high, non-inverted.
// R18: software keeps register-defined TOP at least 0x0003, up to 0xFFFF.
// R19: software keeps TOP at or above every compare register.
// R20: software prefers frequency-correct mode when changing TOP while running.
// R21: counter advances only on prescaler enables of 1, 8, 64, 256, 1024.
// R22: compare output mode zero leaves the waveform output untouched.
// R23: reset clears each channel waveform output to zero.
// R24: counter, compares, buffers, capture are 16 bits, synchronous on enable.
package tfp_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_CMPA = 5'h08;
  localparam logic [4:0] OFS_CMPB = 5'h0C;
  localparam logic [4:0] OFS_CAPT = 5'h10;
  localparam logic [4:0] OFS_FLAGS = 5'h14;
  localparam logic [4:0] OFS_PINCFG = 5'h18;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  // pin config fields
  localparam int PIN_DIR_LSB = 0;
  localparam int PIN_ROUTE_LSB = 4;
  // flag bits
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  // fixed top values
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  // waveform mode codes
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PC_CAPT = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
  // compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  // prescaler selects and tap masks
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;
  localparam logic [31:0] RDATA_IDLE = 32'h00000000;

  typedef enum logic [1:0] {
    FAM_OFF = 2'b00,
    FAM_FAST = 2'b01,
    FAM_PHASE = 2'b10
  } tfp_family_e;

  typedef struct packed {
    logic [15:0] cnt;
    logic down;
    logic [15:0] ocra;
    logic [15:0] ocrb;
    logic [15:0] bufa;
    logic [15:0] bufb;
    logic [15:0] icr;
    logic wf_a;
    logic wf_b;
    logic [3:0] flags;
    logic [3:0] mode;
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] cs;
    logic [1:0] dir;
    logic [1:0] route;
    logic [9:0] presc;
    logic tick;
    logic wait_req;
    logic [31:0] rdata;
    logic pin_a;
    logic pin_a_oe;
    logic pin_b;
    logic pin_b_oe;
  } tfp_state_s;
endpackage

// >>> test/tfp_timer16_pwm_monitor.sv
// port-level assertions for the 16-bit timer pwm block
`timescale 1ns/100ps
module tfp_timer16_pwm_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // waveform and pins
  input wire logic waveform_output_a,
  input wire logic waveform_output_b,
  input wire logic pin_a_out,
  input wire logic pin_a_oe,
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  input wire logic timer_clock_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_wait_single: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("access not answered after one wait cycle");
  a_wait_release: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_hold: assert property ($changed(readdata) |-> !waitrequest)
    else $error("read data moved outside an answer");
  a_pin_a_copy: assert property (pin_a_oe |-> pin_a_out == waveform_output_a)
    else $error("pin a does not carry waveform a");
  a_pin_b_copy: assert property (pin_b_oe |-> pin_b_out == waveform_output_b)
    else $error("pin b does not carry waveform b");
  // checked through reset itself, so the default disable is overridden
  a_reset_clear: assert property (disable iff (1'b0)
    rst |=> !waveform_output_a && !waveform_output_b && !pin_a_oe && !pin_b_oe)
    else $error("outputs not cleared by reset");
  a_wave_a_tick: assert property ($changed(waveform_output_a) |-> $past(timer_clock_enable))
    else $error("waveform a moved without a timer tick");
  a_wave_b_tick: assert property ($changed(waveform_output_b) |-> $past(timer_clock_enable))
    else $error("waveform b moved without a timer tick");
endmodule

// >>> test/testbench.sv
// self-checking bench for the 16-bit timer pwm block
`timescale 1ns/100ps
module testbench;
  logic clk, rst, read, write, probe;
  logic [4:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, n;
  logic waitrequest, waveform_output_a, waveform_output_b;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, timer_clock_enable;
  logic [5:0] pins;
  int n_mismatch, n_checks, gap;
  logic [31:0] notes[$];

  tfp_timer16_pwm i_tfp_timer16_pwm (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .waveform_output_a(waveform_output_a), .waveform_output_b(waveform_output_b), .pin_a_out(pin_a_out),
    .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .timer_clock_enable(timer_clock_enable));

  assign pins = {pin_b_out, pin_b_oe, pin_a_oe, pin_a_out, waveform_output_b, waveform_output_a};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [1:0] a, input logic [1:0] b,
    input logic [2:0] c);
    return {21'h0, c, b, a, m};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [4:0] a, input logic [31:0] e);
    notes.push_back(e);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    @(posedge clk);
  endtask

  // expected {pin_b_out, pin_b_oe, pin_a_oe, pin_a_out, waveform b, waveform a}
  task look(input logic [5:0] e);
    notes.push_back({26'h0, e});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask

  // returns at the edge where a tick is applied, leaving a full tick period for checks
  task step(input int k);
    repeat (k) begin
      do @(posedge clk); while (timer_clock_enable !== 1'b1);
    end
  endtask

  // edges between two ticks of the selected prescaler tap
  task period(input logic [2:0] c, input logic [31:0] e);
    wr(tfp_pkg::OFS_CTRL, ctrl(4'h0, tfp_pkg::COM_OFF, tfp_pkg::COM_OFF, c));
    step(1);
    gap = 0;
    do begin
      @(posedge clk);
      gap++;
    end while (timer_clock_enable !== 1'b1);
    check(gap, e);
  endtask

  // fixed tops mask compare writes, register tops keep all bits
  task mask(input logic [3:0] m, input logic [31:0] e);
    wr(tfp_pkg::OFS_CTRL, ctrl(m, tfp_pkg::COM_OFF, tfp_pkg::COM_OFF, 3'h0));
    wr(tfp_pkg::OFS_CMPB, 32'hFFFF);
    rd(tfp_pkg::OFS_CMPB, e);
  endtask

  always @(posedge clk) begin
    if ((read && !waitrequest) || probe) begin
      n = notes.pop_front();
      check(read ? readdata : {26'h0, pins}, n);
    end
  end

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    probe = 1'b0;
    address = 5'h00;
    byteenable = 4'hF;
    writedata = 32'h0;
    n_mismatch = 0;
    n_checks = 0;
    void'($urandom(96237));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(5'h1C, $urandom);
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    look(6'h00);
    // fast pwm, 8-bit top, a inverting, b non-inverting
    wr(tfp_pkg::OFS_PINCFG, 32'h13);
    wr(tfp_pkg::OFS_CTRL, ctrl(tfp_pkg::MODE_FAST8, tfp_pkg::COM_INV, tfp_pkg::COM_NONINV, 3'h0));
    wr(tfp_pkg::OFS_CMPA, $urandom & 32'h0000FF00 | 32'h34);
    rd(tfp_pkg::OFS_CMPA, 32'h34);
    wr(tfp_pkg::OFS_CMPB, 32'h2);
    wr(tfp_pkg::OFS_COUNT, 32'hFF);
    wr(tfp_pkg::OFS_CTRL, ctrl(tfp_pkg::MODE_FAST8, tfp_pkg::COM_INV, tfp_pkg::COM_NONINV, tfp_pkg::CS_DIV64));
    step(1);
    rd(tfp_pkg::OFS_FLAGS, 32'h1);
    look(6'b001101);
    step(3);
    rd(tfp_pkg::OFS_FLAGS, 32'h5);
    look(6'b101111);
    rd(tfp_pkg::OFS_COUNT, 32'h3);
    period(tfp_pkg::CS_DIV64, 64);
    // phase correct, capture top of 5; stop first so a stray tick cannot disturb setup
    wr(tfp_pkg::OFS_CTRL, 32'h0);
    wr(tfp_pkg::OFS_FLAGS, 32'hF);
    wr(tfp_pkg::OFS_CTRL, ctrl(tfp_pkg::MODE_PC_CAPT, tfp_pkg::COM_INV, tfp_pkg::COM_NONINV, 3'h0));
    wr(tfp_pkg::OFS_CAPT, 32'h5);
    wr(tfp_pkg::OFS_PINCFG, 32'h33);
    wr(tfp_pkg::OFS_CMPA, 32'h4);
    wr(tfp_pkg::OFS_CMPB, 32'h0);
    wr(tfp_pkg::OFS_COUNT, 32'h3);
    wr(tfp_pkg::OFS_CTRL, ctrl(tfp_pkg::MODE_PC_CAPT, tfp_pkg::COM_INV, tfp_pkg::COM_NONINV, tfp_pkg::CS_DIV64));
    step(3);
    rd(tfp_pkg::OFS_FLAGS, 32'h8);
    step(1);
    look(6'b111010);
    step(4);
    rd(tfp_pkg::OFS_FLAGS, 32'hF);
    look(6'b011000);
    rd(tfp_pkg::OFS_COUNT, 32'h1);
    // fast pwm, compare a as top, toggle on a, b off
    wr(tfp_pkg::OFS_CTRL, 32'h0);
    wr(tfp_pkg::OFS_FLAGS, 32'hF);
    wr(tfp_pkg::OFS_CTRL, ctrl(tfp_pkg::MODE_FAST_CMPA, tfp_pkg::COM_TOGGLE, tfp_pkg::COM_OFF, 3'h0));
    wr(tfp_pkg::OFS_CMPA, 32'h7);
    wr(tfp_pkg::OFS_COUNT, 32'h3);
    wr(tfp_pkg::OFS_CTRL, ctrl(tfp_pkg::MODE_FAST_CMPA, tfp_pkg::COM_TOGGLE, tfp_pkg::COM_OFF, tfp_pkg::CS_DIV64));
    step(2);
    rd(tfp_pkg::OFS_FLAGS, 32'h3);
    look(6'b001101);
    step(8);
    look(6'b001000);
    rd(tfp_pkg::OFS_FLAGS, 32'h7);
    rd(tfp_pkg::OFS_COUNT, 32'h0);
    mask(tfp_pkg::MODE_PC8, 32'h00FF);
    mask(tfp_pkg::MODE_PC9, 32'h01FF);
    mask(tfp_pkg::MODE_PC10, 32'h03FF);
    mask(tfp_pkg::MODE_FAST9, 32'h01FF);
    mask(tfp_pkg::MODE_FAST10, 32'h03FF);
    mask(tfp_pkg::MODE_FAST_CAPT, 32'hFFFF);
    mask(tfp_pkg::MODE_PC_CMPA, 32'hFFFF);
    // only byte lane 1 may land
    wr(tfp_pkg::OFS_CAPT, 32'hFFFF);
    byteenable <= 4'h2;
    wr(tfp_pkg::OFS_CAPT, $urandom & 32'hFFFF00FF | 32'h1200);
    byteenable <= 4'hF;
    rd(tfp_pkg::OFS_CAPT, 32'h12FF);
    period(tfp_pkg::CS_DIV1, 1);
    period(tfp_pkg::CS_DIV8, 8);
    period(tfp_pkg::CS_DIV256, 256);
    period(tfp_pkg::CS_DIV1024, 1024);
    results();
  end

  // the sequence needs roughly 4100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule

bind tfp_timer16_pwm tfp_timer16_pwm_monitor i_tfp_timer16_pwm_monitor (.clk(clk), .rst(rst), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest), .waveform_output_a(waveform_output_a),
  .waveform_output_b(waveform_output_b), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
  .pin_b_oe(pin_b_oe), .timer_clock_enable(timer_clock_enable));
